// [rtl/cag_pkg.sv]
// package for the cpu address generation block
// Contract
// - sequential fetch advances the program counter by the instruction byte count
// - relative branch adds sign-extended 8-bit displacement to next instruction address
// - short branch and all conditional branches use the relative target
// - absolute call and branch load the 16-bit immediate word into the counter
// - table call reads vector entry at 40H plus twice bits 1 to 5
// - register-indirect branch copies the accumulator pair into the counter
// - direct addressing uses the 16-bit immediate unchanged as operand address
// - short direct maps an 8-bit operand into the window FE20H to FF1FH
// - short direct: bits 15-9 ones, bit 8 set only for operands 00H-1FH
// - special register address is FFH upper byte with operand low byte
// - 3-bit code picks one of eight registers; pairs pick one of four
// - register indirect uses second index or base pointer pair as address
// - based address is base pointer plus zero-extended offset, carry dropped
// - push, pop, call, return and interrupt save address through the stack pointer
package cag_pkg;
    localparam logic [15:0] CAG_PC_RESET     = 16'h0000;
    localparam logic [15:0] CAG_SP_RESET     = 16'h0000;
    localparam logic [15:0] CAG_VECTOR_BASE  = 16'h0040;
    localparam logic [6:0]  CAG_SADDR_HIGH   = 7'h7f;
    localparam logic [7:0]  CAG_SADDR_SFR_LIM = 8'h1f;
    localparam logic [7:0]  CAG_SFR_PAGE     = 8'hff;
    localparam int          CAG_NUM_REGS     = 8;

    // next program counter source
    typedef enum logic [5:0] {
        CAG_PC_SEQ   = 6'b000001,
        CAG_PC_REL   = 6'b000010,
        CAG_PC_ABS   = 6'b000100,
        CAG_PC_TABLE = 6'b001000,
        CAG_PC_ACC   = 6'b010000,
        CAG_PC_HOLD  = 6'b100000
    } cag_pc_op_t;

    // operand address mode
    typedef enum logic [6:0] {
        CAG_EA_NONE   = 7'b0000001,
        CAG_EA_DIRECT = 7'b0000010,
        CAG_EA_SHORT  = 7'b0000100,
        CAG_EA_SFR    = 7'b0001000,
        CAG_EA_IND    = 7'b0010000,
        CAG_EA_BASED  = 7'b0100000,
        CAG_EA_STACK  = 7'b1000000
    } cag_ea_mode_t;

    // stack pointer action
    typedef enum logic [3:0] {
        CAG_SP_NONE  = 4'b0001,
        CAG_SP_PUSH  = 4'b0010,
        CAG_SP_POP   = 4'b0100,
        CAG_SP_LOAD  = 4'b1000
    } cag_sp_op_t;

    // register pair codes
    localparam logic [1:0] CAG_RP_ACC  = 2'h0;
    localparam logic [1:0] CAG_RP_BC   = 2'h1;
    localparam logic [1:0] CAG_RP_SIDX = 2'h2;
    localparam logic [1:0] CAG_RP_BASE = 2'h3;
endpackage

// [rtl/cag_regs_if.sv]
// interface between the address generator and its register file
`timescale 1ns/1ps
interface cag_regs_if;
    logic [2:0]  rd_sel;
    logic [7:0]  rd_data;
    logic [1:0]  rp_sel;
    logic [15:0] rp_data;
    logic [15:0] acc_pair;
    logic [15:0] sidx_pair;
    logic [15:0] base_pair;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [7:0]  wr_data;
    logic        wrp_en;
    logic [1:0]  wrp_sel;
    logic [15:0] wrp_data;
    modport gen (output rd_sel, rp_sel, wr_en, wr_sel, wr_data, wrp_en, wrp_sel, wrp_data,
                 input rd_data, rp_data, acc_pair, sidx_pair, base_pair);
    modport file (input rd_sel, rp_sel, wr_en, wr_sel, wr_data, wrp_en, wrp_sel, wrp_data,
                  output rd_data, rp_data, acc_pair, sidx_pair, base_pair);
endinterface

// [rtl/cag_reg_file.sv]
// eight 8-bit general registers, addressable as four pairs
`timescale 1ns/1ps
module cag_reg_file
    import cag_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    cag_regs_if.file  regs
);
    logic [7:0] reg_q [CAG_NUM_REGS];
    logic [7:0] reg_d [CAG_NUM_REGS];

    always_comb
    begin
        reg_d = reg_q;
        if (regs.wr_en)
        begin
            reg_d[regs.wr_sel] = regs.wr_data;
        end
        if (regs.wrp_en)
        begin
            reg_d[{regs.wrp_sel, 1'b0}] = regs.wrp_data[7:0];
            reg_d[{regs.wrp_sel, 1'b1}] = regs.wrp_data[15:8];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            for (int i = 0; i < CAG_NUM_REGS; i++)
            begin
                reg_q[i] <= 8'h00;
            end
        end
        else
        begin
            reg_q <= reg_d;
        end
    end

    // pair n is low register 2n, high register 2n+1
    assign regs.rd_data   = reg_q[regs.rd_sel];
    assign regs.rp_data   = {reg_q[{regs.rp_sel, 1'b1}], reg_q[{regs.rp_sel, 1'b0}]};
    assign regs.acc_pair  = {reg_q[1], reg_q[0]};
    assign regs.sidx_pair = {reg_q[5], reg_q[4]};
    assign regs.base_pair = {reg_q[7], reg_q[6]};
endmodule

// [rtl/cag_top.sv]
// address generation: next program counter and operand effective address
`timescale 1ns/1ps
module cag_top
    import cag_pkg::*;
(
    input  wire logic         i_clock,
    input  wire logic         i_rst_b,
    input  wire logic         i_step,
    input  wire logic [1:0]   i_insn_len,
    input  wire cag_pc_op_t   i_pc_op,
    input  wire logic         i_cond_taken,
    input  wire logic [7:0]   i_branch_displacement,
    input  wire logic [15:0]  i_absolute_target_word,
    input  wire logic [7:0]   i_opcode,
    input  wire logic [15:0]  i_table_entry,
    input  wire cag_ea_mode_t i_ea_mode,
    input  wire logic [7:0]   i_operand_byte,
    input  wire logic         i_ind_use_base,
    input  wire cag_sp_op_t   i_sp_op,
    input  wire logic [15:0]  i_sp_load,
    input  wire logic [2:0]   i_reg_sel,
    input  wire logic [1:0]   i_register_pair_operand,
    input  wire logic         i_reg_wr,
    input  wire logic [7:0]   i_reg_wr_data,
    input  wire logic         i_pair_wr,
    input  wire logic [15:0]  i_pair_wr_data,
    output logic      [15:0]  o_pc,
    output logic      [15:0]  o_table_addr,
    output logic      [15:0]  o_ea,
    output logic      [15:0]  o_ea_hi,
    output logic              o_ea_valid,
    output logic      [15:0]  o_sp,
    output logic      [7:0]   o_reg_data,
    output logic      [15:0]  o_pair_data
);
    cag_regs_if regs ();

    cag_reg_file u_reg_file (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .regs    (regs)
    );

    assign regs.rd_sel   = i_reg_sel;
    assign regs.rp_sel   = i_register_pair_operand;
    assign regs.wr_en    = i_reg_wr;
    assign regs.wr_sel   = i_reg_sel;
    assign regs.wr_data  = i_reg_wr_data;
    assign regs.wrp_en   = i_pair_wr;
    assign regs.wrp_sel  = i_register_pair_operand;
    assign regs.wrp_data = i_pair_wr_data;

    // sign-extend and add a byte displacement, dropping any carry out
    function automatic logic [15:0] cag_rel(input logic [15:0] base, input logic [7:0] disp);
        cag_rel = 16'(base + {{8{disp[7]}}, disp});
    endfunction

    // short direct: bit 8 set only for the sfr part of the window
    function automatic logic [15:0] cag_saddr(input logic [7:0] op);
        cag_saddr = {CAG_SADDR_HIGH, (op <= CAG_SADDR_SFR_LIM), op};
    endfunction

    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [15:0] pc_next_seq;
    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [15:0] ea_q;
    logic [15:0] ea_d;
    logic [15:0] ea_hi_q;
    logic [15:0] ea_hi_d;
    logic        ea_valid_q;
    logic        ea_valid_d;
    logic [15:0] table_addr_q;
    logic [15:0] table_addr_d;
    logic [7:0]  reg_data_q;
    logic [7:0]  reg_data_d;
    logic [15:0] pair_data_q;
    logic [15:0] pair_data_d;

    // address of the instruction that follows the current one
    assign pc_next_seq = 16'(pc_q + {14'h0000, i_insn_len});

    // program counter group
    always_comb
    begin
        pc_d = pc_q;
        if (i_step)
        begin
            case (i_pc_op)
                CAG_PC_SEQ:   pc_d = pc_next_seq;
                // untaken conditional falls through to the next instruction
                CAG_PC_REL:   pc_d = i_cond_taken ? cag_rel(pc_next_seq, i_branch_displacement)
                                                  : pc_next_seq;
                CAG_PC_ABS:   pc_d = i_absolute_target_word;
                CAG_PC_TABLE: pc_d = i_table_entry;
                CAG_PC_ACC:   pc_d = regs.acc_pair;
                default:      pc_d = pc_q;
            endcase
        end
    end

    // vector table slot from opcode bits 1..5, always even
    always_comb
    begin
        table_addr_d = CAG_VECTOR_BASE | {10'h000, i_opcode[5:1], 1'b0};
    end

    // register read port, registered so the data outputs come from flops
    always_comb
    begin
        reg_data_d  = regs.rd_data;
        pair_data_d = regs.rp_data;
    end

    // operand address and stack pointer group
    always_comb
    begin
        ea_d       = ea_q;
        ea_hi_d    = ea_hi_q;
        ea_valid_d = 1'b0;
        sp_d       = sp_q;
        case (i_ea_mode)
            CAG_EA_NONE:
            begin
                ea_valid_d = 1'b0;
            end
            CAG_EA_DIRECT:
            begin
                ea_d       = i_absolute_target_word;
                ea_valid_d = 1'b1;
            end
            CAG_EA_SHORT:
            begin
                // word operands rely on an even operand from software
                ea_d       = cag_saddr(i_operand_byte);
                ea_valid_d = 1'b1;
            end
            CAG_EA_SFR:
            begin
                ea_d       = {CAG_SFR_PAGE, i_operand_byte};
                ea_valid_d = 1'b1;
            end
            CAG_EA_IND:
            begin
                ea_d       = i_ind_use_base ? regs.base_pair : regs.sidx_pair;
                ea_valid_d = 1'b1;
            end
            CAG_EA_BASED:
            begin
                ea_d       = 16'(regs.base_pair + {8'h00, i_operand_byte});
                ea_valid_d = 1'b1;
            end
            CAG_EA_STACK:
            begin
                ea_valid_d = 1'b1;
                // pointer is trusted to stay in internal ram
                case (i_sp_op)
                    CAG_SP_PUSH:
                    begin
                        ea_hi_d = 16'(sp_q - 16'h0001);
                        ea_d    = 16'(sp_q - 16'h0002);
                        sp_d    = 16'(sp_q - 16'h0002);
                    end
                    CAG_SP_POP:
                    begin
                        ea_d    = sp_q;
                        ea_hi_d = 16'(sp_q + 16'h0001);
                        sp_d    = 16'(sp_q + 16'h0002);
                    end
                    default:
                    begin
                        // call and return reads leave the pointer where it is
                        ea_d    = sp_q;
                        ea_hi_d = 16'(sp_q + 16'h0001);
                    end
                endcase
            end
            default:
            begin
                ea_valid_d = 1'b0;
            end
        endcase
        if (i_sp_op == CAG_SP_LOAD)
        begin
            sp_d = i_sp_load;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            pc_q         <= CAG_PC_RESET;
            sp_q         <= CAG_SP_RESET;
            ea_q         <= 16'h0000;
            ea_hi_q      <= 16'h0000;
            ea_valid_q   <= 1'b0;
            table_addr_q <= 16'h0000;
            reg_data_q   <= 8'h00;
            pair_data_q  <= 16'h0000;
        end
        else
        begin
            pc_q         <= pc_d;
            sp_q         <= sp_d;
            ea_q         <= ea_d;
            ea_hi_q      <= ea_hi_d;
            ea_valid_q   <= ea_valid_d;
            table_addr_q <= table_addr_d;
            reg_data_q   <= reg_data_d;
            pair_data_q  <= pair_data_d;
        end
    end

    assign o_pc         = pc_q;
    assign o_sp         = sp_q;
    assign o_ea         = ea_q;
    assign o_ea_hi      = ea_hi_q;
    assign o_ea_valid   = ea_valid_q;
    assign o_table_addr = table_addr_q;
    assign o_reg_data   = reg_data_q;
    assign o_pair_data  = pair_data_q;
endmodule

// [verif/cag_mem_model.sv]
// vector table memory model answering table reads
`timescale 1ns/1ps
module cag_mem_model
(
    input  wire logic [15:0] i_addr,
    output logic      [15:0] o_word
);
    // contents differ at every word so a wrong index shows
    assign o_word = ~i_addr;
endmodule

// [verif/cag_top_props.sv]
// concurrent checks on the address generation ports
`timescale 1ns/1ps
module cag_top_props
    import cag_pkg::*;
(
    input wire logic         i_clock,
    input wire logic         i_rst_b,
    input wire logic         i_step,
    input wire logic [1:0]   i_insn_len,
    input wire cag_pc_op_t   i_pc_op,
    input wire logic         i_cond_taken,
    input wire logic [7:0]   i_branch_displacement,
    input wire logic [15:0]  i_absolute_target_word,
    input wire logic [7:0]   i_opcode,
    input wire cag_ea_mode_t i_ea_mode,
    input wire logic [7:0]   i_operand_byte,
    input wire cag_sp_op_t   i_sp_op,
    input wire logic [15:0]  o_pc,
    input wire logic [15:0]  o_table_addr,
    input wire logic [15:0]  o_ea,
    input wire logic [15:0]  o_ea_hi,
    input wire logic         o_ea_valid,
    input wire logic [15:0]  o_sp
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_push;
        i_ea_mode == CAG_EA_STACK && i_sp_op == CAG_SP_PUSH;
    endsequence
    sequence s_pair_addr;
        o_ea_valid && o_ea_hi == o_ea + 16'h0001;
    endsequence
    chk_seq_advance: assert property (i_step && (i_pc_op == CAG_PC_SEQ ||
        (i_pc_op == CAG_PC_REL && !i_cond_taken)) |=> o_pc == $past(o_pc) + $past(i_insn_len))
        else $error("sequential pc wrong");
    chk_rel_target: assert property (i_step && i_pc_op == CAG_PC_REL && i_cond_taken |=>
        o_pc == $past(o_pc) + $past(i_insn_len) + {{8{$past(i_branch_displacement[7])}},
        $past(i_branch_displacement)}) else $error("relative target wrong");
    chk_pc_hold: assert property (!i_step || i_pc_op == CAG_PC_HOLD |=> $stable(o_pc))
        else $error("pc moved without step");
    chk_table_index: assert property (1'b1 |=>
        o_table_addr == {9'h000, 1'b1, $past(i_opcode[5:1]), 1'b0}) else $error("table addr");
    chk_direct_ea: assert property (i_ea_mode == CAG_EA_DIRECT |=>
        o_ea_valid && o_ea == $past(i_absolute_target_word)) else $error("direct ea wrong");
    chk_short_ea: assert property (i_ea_mode == CAG_EA_SHORT |=> o_ea ==
        {7'h7f, ($past(i_operand_byte) <= 8'h1f), $past(i_operand_byte)}) else $error("short ea");
    chk_sfr_ea: assert property (i_ea_mode == CAG_EA_SFR |=>
        o_ea == {8'hff, $past(i_operand_byte)}) else $error("sfr ea wrong");
    chk_push_pointer: assert property (s_push |=> o_sp == $past(o_sp) - 16'h0002 &&
        o_ea == $past(o_sp) - 16'h0002 ##0 s_pair_addr) else $error("push address wrong");
    chk_idle_ea: assert property (i_ea_mode == CAG_EA_NONE |=> !o_ea_valid && $stable(o_ea))
        else $error("ea changed when idle");
endmodule
bind cag_top cag_top_props u_props (.*);

// [verif/tb_cpu_address_generation.sv]
// self-checking bench for the address generation block
`timescale 1ns/1ps
module tb_cpu_address_generation
    import cag_pkg::*;
;
    logic         i_clock = 1'b0;
    logic         i_rst_b = 1'b0;
    logic         i_step, i_cond_taken, i_ind_use_base, i_reg_wr, i_pair_wr, o_ea_valid;
    logic [1:0]   i_insn_len, i_register_pair_operand;
    logic [2:0]   i_reg_sel;
    logic [7:0]   i_branch_displacement, i_opcode, i_operand_byte, i_reg_wr_data, o_reg_data;
    logic [15:0]  i_absolute_target_word, i_table_entry, i_sp_load, i_pair_wr_data, epc;
    logic [15:0]  o_pc, o_table_addr, o_ea, o_ea_hi, o_sp, o_pair_data;
    cag_pc_op_t   i_pc_op;
    cag_ea_mode_t i_ea_mode;
    cag_sp_op_t   i_sp_op;
    int           num_errors = 0;
    int           samples_checked = 0;
    always #12.5 i_clock = ~i_clock;
    cag_top dut (.*);
    cag_mem_model mem (.i_addr(o_table_addr), .o_word(i_table_entry));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle();
        {i_step, i_reg_wr, i_pair_wr} = 3'h0;
        i_pc_op = CAG_PC_HOLD;
        i_ea_mode = CAG_EA_NONE;
        i_sp_op = CAG_SP_NONE;
    endtask
    task automatic step(input cag_pc_op_t op);
        i_step = 1'b1;
        i_pc_op = op;
        @(negedge i_clock);
        idle();
        // one idle cycle so the next request never rewrites a strobe in one step
        @(negedge i_clock);
    endtask
    task automatic ea(input cag_ea_mode_t m, input cag_sp_op_t s);
        i_ea_mode = m;
        i_sp_op = s;
        @(negedge i_clock);
        idle();
        @(negedge i_clock);
    endtask
    task automatic wpair(input logic [1:0] p, input logic [15:0] v);
        i_pair_wr = 1'b1;
        i_register_pair_operand = p;
        i_pair_wr_data = v;
        repeat (2) @(negedge i_clock);
        idle();
        @(negedge i_clock);
    endtask
    task automatic t_pc();
        logic [7:0] d [3] = '{8'h80, 8'h7f, 8'h10};
        for (int n = 1; n <= 3; n++)
        begin
            i_insn_len = 2'(n);
            step(CAG_PC_SEQ);
            epc = epc + 16'(n);
            chk(o_pc, epc);
        end
        for (int k = 0; k < 3; k++)
        begin
            i_branch_displacement = d[k];
            i_cond_taken = (k < 2);
            step(CAG_PC_REL);
            epc = epc + 16'h0003 + ((k < 2) ? {{8{d[k][7]}}, d[k]} : 16'h0000);
            chk(o_pc, epc);
        end
        i_absolute_target_word = 16'hbeef;
        step(CAG_PC_ABS);
        chk(o_pc, 16'hbeef);
        $display("test pc done");
    endtask
    task automatic t_table();
        i_opcode = 8'h3e;
        @(negedge i_clock);
        chk(o_table_addr, 16'h007e);
        step(CAG_PC_TABLE);
        chk(o_pc, 16'hff81);
        i_opcode = 8'hc1;
        @(negedge i_clock);
        chk(o_table_addr, 16'h0040);
        wpair(2'd0, 16'h1234);
        chk(o_pair_data, 16'h1234);
        step(CAG_PC_ACC);
        chk(o_pc, 16'h1234);
        i_reg_wr = 1'b1;
        i_reg_sel = 3'd3;
        i_reg_wr_data = 8'h5c;
        i_register_pair_operand = 2'd1;
        repeat (2) @(negedge i_clock);
        idle();
        @(negedge i_clock);
        chk({8'h00, o_reg_data}, 16'h005c);
        chk(o_pair_data, 16'h5c00);
        $display("test table done");
    endtask
    task automatic t_ea();
        logic [7:0]  so [4] = '{8'h80, 8'hff, 8'h00, 8'h1f};
        logic [15:0] se [4] = '{16'hfe80, 16'hfeff, 16'hff00, 16'hff1f};
        i_absolute_target_word = 16'h1357;
        ea(CAG_EA_DIRECT, CAG_SP_NONE);
        chk(o_ea, 16'h1357);
        // even operand first, as word accesses need
        for (int k = 0; k < 4; k++)
        begin
            i_operand_byte = so[k];
            ea(CAG_EA_SHORT, CAG_SP_NONE);
            chk(o_ea, se[k]);
        end
        i_operand_byte = 8'h20;
        ea(CAG_EA_SFR, CAG_SP_NONE);
        chk(o_ea, 16'hff20);
        wpair(2'd2, 16'h4242);
        wpair(2'd3, 16'hfff0);
        for (int b = 0; b < 2; b++)
        begin
            i_ind_use_base = b[0];
            ea(CAG_EA_IND, CAG_SP_NONE);
            chk(o_ea, b ? 16'hfff0 : 16'h4242);
        end
        ea(CAG_EA_BASED, CAG_SP_NONE);
        chk(o_ea, 16'h0010);
        $display("test ea done");
    endtask
    task automatic t_stack();
        // pointer kept inside high-speed ram
        i_sp_load = 16'hfee0;
        ea(CAG_EA_NONE, CAG_SP_LOAD);
        chk(o_sp, 16'hfee0);
        ea(CAG_EA_STACK, CAG_SP_PUSH);
        chk(o_sp, 16'hfede);
        chk(o_ea, 16'hfede);
        chk(o_ea_hi, 16'hfedf);
        ea(CAG_EA_STACK, CAG_SP_POP);
        chk(o_sp, 16'hfee0);
        chk(o_ea, 16'hfede);
        chk(o_ea_hi, 16'hfedf);
        ea(CAG_EA_STACK, CAG_SP_NONE);
        chk(o_ea, 16'hfee0);
        chk(o_ea_hi, 16'hfee1);
        chk(o_sp, 16'hfee0);
        $display("test stack done");
    endtask
    task automatic t_reset();
        // mid-run reset brings every output back to its reset value
        i_rst_b = 1'b0;
        repeat (3) @(negedge i_clock);
        i_rst_b = 1'b1;
        chk(o_pc, CAG_PC_RESET);
        chk(o_sp, CAG_SP_RESET);
        chk(o_ea, 16'h0000);
        chk(o_ea_hi, 16'h0000);
        chk({15'h0000, o_ea_valid}, 16'h0000);
        chk(o_table_addr, 16'h0000);
        chk({8'h00, o_reg_data}, 16'h0000);
        chk(o_pair_data, 16'h0000);
        i_insn_len = 2'd2;
        step(CAG_PC_SEQ);
        chk(o_pc, 16'(CAG_PC_RESET + 16'h0002));
        chk(o_pair_data, 16'h0000);
        $display("test reset done");
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        idle();
        {i_cond_taken, i_ind_use_base, i_insn_len, i_register_pair_operand, i_reg_sel} = '0;
        {i_branch_displacement, i_opcode, i_operand_byte, i_reg_wr_data} = '0;
        {i_absolute_target_word, i_sp_load, i_pair_wr_data} = '0;
        repeat (3) @(negedge i_clock);
        i_rst_b = 1'b1;
        epc = CAG_PC_RESET;
        chk(o_pc, CAG_PC_RESET);
        chk(o_sp, CAG_SP_RESET);
        t_pc();
        t_table();
        t_ea();
        t_stack();
        t_reset();
        final_report();
    end
    initial
    begin
        // whole run is well under a hundred cycles
        #5000;
        num_errors++;
        final_report();
    end
endmodule
